/* File: design/tmif_defines.vh */
// Register map, field positions and reset values of the timer match interrupt flags
`ifndef TMIF_DEFINES_VH
`define TMIF_DEFINES_VH

`define TMIF_ADDR_W 8
`define TMIF_OFS_TICK2 8'h00
`define TMIF_OFS_MATCH_A 8'h04
`define TMIF_OFS_MATCH_B 8'h08
`define TMIF_OFS_CTRL 8'h0C
`define TMIF_OFS_SHARED 8'h10
`define TMIF_OFS_STATUS 8'h14
`define TMIF_OFS_MASK 8'h18

`define TMIF_TICK2_FLAG_BIT 4
`define TMIF_TICK2_EN_BIT 0
`define TMIF_T0P_FLAG_BIT 4
`define TMIF_T0A_FLAG_BIT 5
`define TMIF_T1P_FLAG_BIT 6
`define TMIF_T1A_FLAG_BIT 7
`define TMIF_T0P_EN_BIT 0
`define TMIF_T0A_EN_BIT 1
`define TMIF_T1P_EN_BIT 2
`define TMIF_T1A_EN_BIT 3
`define TMIF_T2P_FLAG_BIT 4
`define TMIF_T2A_FLAG_BIT 5
`define TMIF_T2B_FLAG_BIT 6
`define TMIF_T2P_EN_BIT 0
`define TMIF_T2A_EN_BIT 1
`define TMIF_T2B_EN_BIT 2

`define TMIF_CTRL_GIE_BIT 0
`define TMIF_CTRL_SH0_EN_BIT 1
`define TMIF_CTRL_SH1_EN_BIT 2

`define TMIF_EVT_W 8
`define TMIF_EVT_TICK2 0
`define TMIF_EVT_T0P 1
`define TMIF_EVT_T0A 2
`define TMIF_EVT_T1P 3
`define TMIF_EVT_T1A 4
`define TMIF_EVT_T2P 5
`define TMIF_EVT_T2A 6
`define TMIF_EVT_T2B 7

`define TMIF_VEC_TICK2 2'h0
`define TMIF_VEC_SHARED0 2'h1
`define TMIF_VEC_SHARED1 2'h2

`define TMIF_RST_BYTE 8'h00
`define TMIF_RST_WORD 32'h00000000

`endif

/* File: design/tmif_sticky.v */
// Bank of sticky flags: hardware set wins over software write or clear
`timescale 1ns/100ps
`default_nettype none
module tmif_sticky #(
  parameter N = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [N-1:0] set,
  input wire [N-1:0] clr,
  input wire wr_en,
  input wire [N-1:0] wr_data,
  output reg [N-1:0] q_reg
);
  reg [N-1:0] q_next;

  always @* begin
    q_next = wr_en ? wr_data : q_reg;
    q_next = (q_next & ~clr) | set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= {N{1'b0}};
    end else begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

/* File: design/tmif_top.v */
// Timer match and second time-base interrupt flags with APB register access
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tmif_defines.vh"
module tmif_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire tick2_evt,
  input wire tmr0_p_evt,
  input wire tmr0_a_evt,
  input wire tmr1_p_evt,
  input wire tmr1_a_evt,
  input wire tmr2_p_evt,
  input wire tmr2_a_evt,
  input wire tmr2_b_evt,
  input wire vec_ack,
  output reg vec_req,
  output reg [1:0] vec_id,
  output reg irq
);
  // Bus handshake and decode
  wire access = psel & penable & pready;
  wire [`TMIF_ADDR_W-1:0] addr = paddr[`TMIF_ADDR_W-1:0];
  wire upper_zero = (paddr[31:`TMIF_ADDR_W] == 24'h000000);

  function hit;
    input [`TMIF_ADDR_W-1:0] a;
    input [`TMIF_ADDR_W-1:0] ofs;
    input hi_ok;
    begin
      hit = hi_ok & (a == ofs);
    end
  endfunction

  wire sel_tick2 = hit(addr, `TMIF_OFS_TICK2, upper_zero);
  wire sel_ma = hit(addr, `TMIF_OFS_MATCH_A, upper_zero);
  wire sel_mb = hit(addr, `TMIF_OFS_MATCH_B, upper_zero);
  wire sel_ctrl = hit(addr, `TMIF_OFS_CTRL, upper_zero);
  wire sel_shared = hit(addr, `TMIF_OFS_SHARED, upper_zero);
  wire sel_status = hit(addr, `TMIF_OFS_STATUS, upper_zero);
  wire sel_mask = hit(addr, `TMIF_OFS_MASK, upper_zero);
  wire sel_any = sel_tick2 | sel_ma | sel_mb | sel_ctrl | sel_shared | sel_status | sel_mask;

  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  // First access edge; the answer follows one cycle later
  wire acc_first = psel & penable & ~pready;

  // Write strobes per register
  wire wr_tick2 = wr & sel_tick2;
  wire wr_ma = wr & sel_ma;
  wire wr_mb = wr & sel_mb;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_shared = wr & sel_shared;
  wire wr_mask = wr & sel_mask;

  // Vector taken by the core
  wire ack_taken = vec_ack & vec_req;

  // Enable bits
  reg tick2_irq_en_reg;
  reg [3:0] ma_en_reg;
  reg [2:0] mb_en_reg;
  reg global_irq_en_reg;
  reg [1:0] shared_en_reg;
  reg [`TMIF_EVT_W-1:0] mask_reg;

  // Request flags, one bank, event order
  wire [`TMIF_EVT_W-1:0] evt;
  wire [`TMIF_EVT_W-1:0] flag;
  reg [`TMIF_EVT_W-1:0] flag_wdata;
  reg flag_wen;
  reg [`TMIF_EVT_W-1:0] flag_clr;

  assign evt[`TMIF_EVT_TICK2] = tick2_evt;
  assign evt[`TMIF_EVT_T0P] = tmr0_p_evt;
  assign evt[`TMIF_EVT_T0A] = tmr0_a_evt;
  assign evt[`TMIF_EVT_T1P] = tmr1_p_evt;
  assign evt[`TMIF_EVT_T1A] = tmr1_a_evt;
  assign evt[`TMIF_EVT_T2P] = tmr2_p_evt;
  assign evt[`TMIF_EVT_T2A] = tmr2_a_evt;
  assign evt[`TMIF_EVT_T2B] = tmr2_b_evt;

  // Writes to one register touch only that register's flags
  always @* begin
    flag_wdata = flag;
    flag_wen = 1'b0;
    if (wr_tick2) begin
      flag_wen = 1'b1;
      flag_wdata[`TMIF_EVT_TICK2] = pwdata[`TMIF_TICK2_FLAG_BIT];
    end
    if (wr_ma) begin
      flag_wen = 1'b1;
      flag_wdata[`TMIF_EVT_T0P] = pwdata[`TMIF_T0P_FLAG_BIT];
      flag_wdata[`TMIF_EVT_T0A] = pwdata[`TMIF_T0A_FLAG_BIT];
      flag_wdata[`TMIF_EVT_T1P] = pwdata[`TMIF_T1P_FLAG_BIT];
      flag_wdata[`TMIF_EVT_T1A] = pwdata[`TMIF_T1A_FLAG_BIT];
    end
    if (wr_mb) begin
      flag_wen = 1'b1;
      flag_wdata[`TMIF_EVT_T2P] = pwdata[`TMIF_T2P_FLAG_BIT];
      flag_wdata[`TMIF_EVT_T2A] = pwdata[`TMIF_T2A_FLAG_BIT];
      flag_wdata[`TMIF_EVT_T2B] = pwdata[`TMIF_T2B_FLAG_BIT];
    end
  end

  // Events set flags regardless of their enables
  tmif_sticky #(
    .N(`TMIF_EVT_W)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(evt),
    .clr(flag_clr),
    .wr_en(flag_wen),
    .wr_data(flag_wdata),
    .q_reg(flag)
  );

  // Flags that become set this cycle
  wire [`TMIF_EVT_W-1:0] flag_next = (flag_wen ? flag_wdata : flag) | evt;
  wire [`TMIF_EVT_W-1:0] flag_rise = flag_next & ~flag & evt;
  wire sh0_set = |flag_rise[`TMIF_EVT_T1A:`TMIF_EVT_T0P];
  wire sh1_set = |flag_rise[`TMIF_EVT_T2B:`TMIF_EVT_T2P];

  // Enabled requests per vector
  wire tick2_req = flag[`TMIF_EVT_TICK2] & tick2_irq_en_reg;
  wire sh0_src = (flag[`TMIF_EVT_T0P] & ma_en_reg[`TMIF_T0P_EN_BIT]) |
                 (flag[`TMIF_EVT_T0A] & ma_en_reg[`TMIF_T0A_EN_BIT]) |
                 (flag[`TMIF_EVT_T1P] & ma_en_reg[`TMIF_T1P_EN_BIT]) |
                 (flag[`TMIF_EVT_T1A] & ma_en_reg[`TMIF_T1A_EN_BIT]);
  wire sh1_src = (flag[`TMIF_EVT_T2P] & mb_en_reg[`TMIF_T2P_EN_BIT]) |
                 (flag[`TMIF_EVT_T2A] & mb_en_reg[`TMIF_T2A_EN_BIT]) |
                 (flag[`TMIF_EVT_T2B] & mb_en_reg[`TMIF_T2B_EN_BIT]);

  // Shared request flags
  reg [1:0] shared_irq_flag_reg;
  reg [1:0] shared_next;
  wire ack_sh0 = ack_taken & (vec_id == `TMIF_VEC_SHARED0);
  wire ack_sh1 = ack_taken & (vec_id == `TMIF_VEC_SHARED1);
  wire ack_tick2 = ack_taken & (vec_id == `TMIF_VEC_TICK2);

  always @* begin
    flag_clr = {`TMIF_EVT_W{1'b0}};
    flag_clr[`TMIF_EVT_TICK2] = ack_tick2;
  end

  always @* begin
    shared_next = shared_irq_flag_reg;
    if (wr_shared) begin
      shared_next = pwdata[1:0];
    end
    if (ack_sh0) begin
      shared_next[0] = 1'b0;
    end
    if (ack_sh1) begin
      shared_next[1] = 1'b0;
    end
    shared_next[0] = shared_next[0] | sh0_set;
    shared_next[1] = shared_next[1] | sh1_set;
  end

  wire sh0_req = shared_irq_flag_reg[0] & shared_en_reg[0] & sh0_src;
  wire sh1_req = shared_irq_flag_reg[1] & shared_en_reg[1] & sh1_src;

  // Global enable, cleared by any serviced vector
  reg gie_next;
  always @* begin
    gie_next = global_irq_en_reg;
    if (wr_ctrl) begin
      gie_next = pwdata[`TMIF_CTRL_GIE_BIT];
    end
    if (ack_taken) begin
      gie_next = 1'b0;
    end
  end

  // Vector request, fixed priority: shared 0, shared 1, time base two
  reg vec_req_next;
  reg [1:0] vec_id_next;
  always @* begin
    vec_req_next = 1'b0;
    vec_id_next = vec_id;
    if (gie_next & ~ack_taken) begin
      if (sh0_req) begin
        vec_req_next = 1'b1;
        vec_id_next = `TMIF_VEC_SHARED0;
      end else if (sh1_req) begin
        vec_req_next = 1'b1;
        vec_id_next = `TMIF_VEC_SHARED1;
      end else if (tick2_req) begin
        vec_req_next = 1'b1;
        vec_id_next = `TMIF_VEC_TICK2;
      end
    end
  end

  // Interrupt status: sticky, cleared by a read, set wins
  wire [`TMIF_EVT_W-1:0] status;
  // A status read clears only the bits it returned; later events stay pending
  wire status_rd = rd & sel_status;
  wire [`TMIF_EVT_W-1:0] status_clr = {`TMIF_EVT_W{status_rd}} & prdata[`TMIF_EVT_W-1:0];
  wire [`TMIF_EVT_W-1:0] status_next = (status & ~status_clr) | evt;
  tmif_sticky #(
    .N(`TMIF_EVT_W)
  ) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set(evt),
    .clr(status_clr),
    .wr_en(1'b0),
    .wr_data({`TMIF_EVT_W{1'b0}}),
    .q_reg(status)
  );

  // Read mux
  reg [31:0] rdata;
  always @* begin
    rdata = `TMIF_RST_WORD;
    if (sel_tick2) begin
      rdata[`TMIF_TICK2_FLAG_BIT] = flag[`TMIF_EVT_TICK2];
      rdata[`TMIF_TICK2_EN_BIT] = tick2_irq_en_reg;
    end
    if (sel_ma) begin
      rdata[`TMIF_T0P_FLAG_BIT] = flag[`TMIF_EVT_T0P];
      rdata[`TMIF_T0A_FLAG_BIT] = flag[`TMIF_EVT_T0A];
      rdata[`TMIF_T1P_FLAG_BIT] = flag[`TMIF_EVT_T1P];
      rdata[`TMIF_T1A_FLAG_BIT] = flag[`TMIF_EVT_T1A];
      rdata[3:0] = ma_en_reg;
    end
    if (sel_mb) begin
      rdata[`TMIF_T2P_FLAG_BIT] = flag[`TMIF_EVT_T2P];
      rdata[`TMIF_T2A_FLAG_BIT] = flag[`TMIF_EVT_T2A];
      rdata[`TMIF_T2B_FLAG_BIT] = flag[`TMIF_EVT_T2B];
      rdata[2:0] = mb_en_reg;
    end
    if (sel_ctrl) begin
      rdata[`TMIF_CTRL_GIE_BIT] = global_irq_en_reg;
      rdata[`TMIF_CTRL_SH0_EN_BIT] = shared_en_reg[0];
      rdata[`TMIF_CTRL_SH1_EN_BIT] = shared_en_reg[1];
    end
    if (sel_shared) begin
      rdata[1:0] = shared_irq_flag_reg;
    end
    if (sel_status) begin
      rdata[`TMIF_EVT_W-1:0] = status;
    end
    if (sel_mask) begin
      rdata[`TMIF_EVT_W-1:0] = mask_reg;
    end
  end

  // Registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick2_irq_en_reg <= 1'b0;
      ma_en_reg <= 4'h0;
      mb_en_reg <= 3'h0;
      global_irq_en_reg <= 1'b0;
      shared_en_reg <= 2'h0;
      shared_irq_flag_reg <= 2'h0;
      mask_reg <= `TMIF_RST_BYTE;
    end else begin
      if (wr_tick2) begin
        tick2_irq_en_reg <= pwdata[`TMIF_TICK2_EN_BIT];
      end
      if (wr_ma) begin
        ma_en_reg <= pwdata[3:0];
      end
      if (wr_mb) begin
        mb_en_reg <= pwdata[2:0];
      end
      if (wr_ctrl) begin
        shared_en_reg <= {pwdata[`TMIF_CTRL_SH1_EN_BIT], pwdata[`TMIF_CTRL_SH0_EN_BIT]};
      end
      if (wr_mask) begin
        mask_reg <= pwdata[`TMIF_EVT_W-1:0];
      end
      global_irq_en_reg <= gie_next;
      shared_irq_flag_reg <= shared_next;
    end
  end

  // Vector outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_req <= 1'b0;
      vec_id <= `TMIF_VEC_TICK2;
    end else begin
      vec_req <= vec_req_next;
      vec_id <= vec_id_next;
    end
  end

  // Level interrupt: any unmasked status bit, this cycle's events included
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_reg);
    end
  end

  // Bus response: one wait state on every transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TMIF_RST_WORD;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & ~sel_any;
      if (acc_first & ~pwrite) begin
        prdata <= rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tmif_checker.sv */
// Concurrent checks on the ports of the timer match interrupt flags
`timescale 1ns/100ps
`default_nettype none
module tmif_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vec_ack,
  input wire logic vec_req,
  input wire logic [1:0] vec_id,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Unmapped address
  wire bad = paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0 || paddr[7:0] > 8'h18;
  sequence s_acc;
    $rose(psel && penable);
  endsequence
  sequence s_rd;
    pready && !pwrite;
  endsequence
  a_rst_quiet: assert property ($past(!presetn) |-> !irq && !vec_req && !pready && vec_id == 2'h0)
    else $error("outputs not clear after reset");
  a_ready_wait: assert property (s_acc |-> !pready ##1 pready)
    else $error("ready not one wait state late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && bad |-> pslverr)
    else $error("no error on unmapped address");
  a_ok_mapped: assert property (pready && !bad |-> !pslverr)
    else $error("error on mapped address");
  a_read_upper: assert property (s_rd |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_tick_pad: assert property (s_rd and paddr == 32'h00000000 |-> prdata[7:5] == 3'h0 && prdata[3:1] == 3'h0)
    else $error("unused time base bits not zero");
  a_matchb_pad: assert property (s_rd and paddr == 32'h00000008 |-> !prdata[7] && !prdata[3])
    else $error("unused match b bits not zero");
  a_vec_ack: assert property (vec_req && vec_ack |=> !vec_req)
    else $error("vector still pending after ack");
endmodule
bind tmif_top tmif_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .vec_ack(vec_ack), .vec_req(vec_req), .vec_id(vec_id), .irq(irq));
`default_nettype wire

/* File: testbench/tmif_top_tb.sv */
// Register and event tests of the timer match interrupt flags
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tmif_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic vec_ack = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] ra;
  logic [31:0] rb;
  logic [7:0] evt = 8'h00;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire vec_req;
  wire irq;
  wire [1:0] vec_id;
  int err_count = 0;
  int check_count = 0;
  tmif_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick2_evt(evt[0]), .tmr0_p_evt(evt[1]), .tmr0_a_evt(evt[2]), .tmr1_p_evt(evt[3]),
    .tmr1_a_evt(evt[4]), .tmr2_p_evt(evt[5]), .tmr2_a_evt(evt[6]), .tmr2_b_evt(evt[7]),
    .vec_ack(vec_ack), .vec_req(vec_req), .vec_id(vec_id), .irq(irq));
  initial forever #25 pclk = ~pclk;
  task final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; d is write data or expected read data
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report;
    end
    `CHK("pslverr", er, pslverr)
    if (!w) `CHK("prdata", d, prdata)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input int i);
    @(posedge pclk);
    evt <= 8'h01 << i;
    @(posedge pclk);
    evt <= 8'h00;
  endtask
  // Wait for a vector, check its id, acknowledge it
  task take_vec(input logic [1:0] id);
    int n;
    n = 0;
    while (vec_req !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK("vec_req", 1'b1, vec_req)
    if (vec_req !== 1'b1) final_report;
    `CHK("vec_id", id, vec_id)
    vec_ack <= 1'b1;
    @(posedge pclk);
    vec_ack <= 1'b0;
    @(posedge pclk);
    `CHK("vec_req", 1'b0, vec_req)
  endtask
  task no_vec;
    repeat (4) @(posedge pclk);
    `CHK("vec_req", 1'b0, vec_req)
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) apb(0, 4 * k, 32'h00000000, 0);
    apb(0, 32'h0000001C, 32'h00000000, 1);
    apb(1, 32'h0000001C, 32'h000000FF, 1);
    apb(1, 32'h00000000, 32'h000000FF, 0);
    apb(0, 32'h00000000, 32'h00000011, 0);
    apb(1, 32'h00000008, 32'h000000FF, 0);
    apb(0, 32'h00000008, 32'h00000077, 0);
    apb(1, 32'h00000004, 32'h000000FF, 0);
    apb(0, 32'h00000004, 32'h000000FF, 0);
    for (int k = 0; k < 3; k++) apb(1, 4 * k, 32'h00000000, 0);
    // Each event sets its own flag and status bit only
    for (int i = 0; i < 8; i++) begin
      ra = (i == 0) ? 32'h00000000 : (i < 5) ? 32'h00000004 : 32'h00000008;
      rb = 32'h00000010 << ((i == 0) ? 0 : (i < 5) ? i - 1 : i - 5);
      pulse(i);
      repeat (2) @(posedge pclk);
      `CHK("irq", 1'b0, irq)
      apb(0, ra, rb, 0);
      apb(0, 32'h00000014, 32'h00000001 << i, 0);
      apb(0, 32'h00000014, 32'h00000000, 0);
      apb(1, ra, 32'h00000000, 0);
    end
    // Unmasked interrupt raised and cleared by status read
    apb(1, 32'h00000018, 32'h00000002, 0);
    pulse(1);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(0, 32'h00000014, 32'h00000002, 0);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    // Vectoring
    apb(1, 32'h0000000C, 32'h00000007, 0);
    no_vec;
    apb(1, 32'h00000004, 32'h00000011, 0);
    take_vec(2'h1);
    apb(0, 32'h00000004, 32'h00000011, 0);
    apb(0, 32'h0000000C, 32'h00000006, 0);
    apb(0, 32'h00000010, 32'h00000002, 0);
    apb(1, 32'h00000004, 32'h00000003, 0);
    pulse(2);
    no_vec;
    apb(1, 32'h0000000C, 32'h00000007, 0);
    take_vec(2'h1);
    apb(1, 32'h00000004, 32'h00000000, 0);
    apb(1, 32'h00000010, 32'h00000000, 0);
    apb(1, 32'h00000000, 32'h00000001, 0);
    apb(1, 32'h0000000C, 32'h00000007, 0);
    pulse(0);
    take_vec(2'h0);
    apb(0, 32'h00000000, 32'h00000001, 0);
    apb(1, 32'h0000000C, 32'h00000007, 0);
    apb(1, 32'h00000008, 32'h00000004, 0);
    pulse(7);
    take_vec(2'h2);
    // Reset in mid-run clears every flag and enable
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) apb(0, 4 * k, 32'h00000000, 0);
    final_report;
  end
endmodule
`default_nettype wire
